// [rtl/ivau_regs.svh]
// Register map, field positions and codes of the interrupt vector unit.
// Assumes an 8-bit register port with a 4-bit word index.
`ifndef IVAU_REGS_SVH
`define IVAU_REGS_SVH

// ************************************************************
// Register index
// ************************************************************
`define IVAU_A_SER_STAT  4'h0
`define IVAU_A_DMA_STAT  4'h1
`define IVAU_A_TMR_STAT  4'h2
`define IVAU_A_SER_EN    4'h3
`define IVAU_A_DMA_EN    4'h4
`define IVAU_A_TMR_EN    4'h5
`define IVAU_A_FIX_VEC   4'h6
`define IVAU_A_MOD_VEC   4'h7
`define IVAU_A_CTRL      4'h8
`define IVAU_A_EVT_STAT  4'h9
`define IVAU_A_EVT_MASK  4'hA

// ************************************************************
// Fields and reset values
// ************************************************************
`define IVAU_CTL_IPC     7
`define IVAU_CTL_ACK_HI  6
`define IVAU_CTL_ACK_LO  5
`define IVAU_CTL_VOS     4
`define IVAU_ACK_NONE    2'h0
`define IVAU_ACK_SINGLE  2'h1
`define IVAU_ACK_DOUBLE  2'h2
`define IVAU_EVT_VECTOR  0
`define IVAU_EVT_STRAY   1
`define IVAU_RST_BYTE    8'h00
`define IVAU_NO_CODE     6'h00

`endif

// [rtl/ivau_pkg.sv]
// Types shared by the interrupt vector unit.
// Assumes nothing beyond the register header.
package ivau_pkg;

   // ************************************************************
   // Acknowledge sequencer states
   // ************************************************************
   typedef enum logic [1:0]
   {
      IVAU_IDLE,
      IVAU_WAIT_SECOND,
      IVAU_DRIVE
   } ivau_ack_state_e;

   typedef logic [7:0] ivau_byte_t;

endpackage : ivau_pkg

// [rtl/ivau_top.sv]
// Interrupt request latching, masking and vector output on acknowledge.
// Assumes source requests come from logic on core_clk; cpu_ack_n is a pin.
//
// What this block does
// - timer status read-only, bits 7..4 reset zero
// - timer status bits mirror timer channel requests
// - low nibble of timer registers reads zero
// - serial enable register cleared at reset
// - DMA enable register cleared at reset
// - timer enables in bits 7..4, reset zero
// - enabled pending sources and unmasked pending events raise the request
// - vector goes only on the low byte
// - fixed mode outputs whole fixed vector byte
// - modified mode: two host bits, six source bits
// - select bit chooses fixed or modified vector
// - ack type 00 none, 01 single, 10 double
// - highest priority pending source sets the code
// - no-acknowledge type never drives the bus
// - single type drives on first acknowledge pulse
// - double type ignores first, drives on second
// - acknowledge without request drives no vector
`include "ivau_regs.svh"

module ivau_top
   import ivau_pkg::*;
(
   input  wire logic       core_clk,     // 20 MHz clock
   input  wire logic       rst,          // Synchronous reset
   input  wire logic [3:0] reg_addr,     // Register index
   input  wire logic [7:0] reg_wdata,    // Write data
   input  wire logic       reg_wr,       // Write strobe
   input  wire logic       reg_rd,       // Read strobe
   output logic      [7:0] reg_rdata,    // Read data, cycle after strobe
   input  wire logic [7:0] serial_req,   // Serial channel requests
   input  wire logic [7:0] dma_req,      // DMA requests, odd end, even error
   input  wire logic [3:0] timer_req,    // Timer channel 3..0 requests
   input  wire logic       cpu_ack_n,    // Acknowledge pin, active low
   output logic            cpu_irq,      // Interrupt request to host
   output logic      [7:0] data_lo_out,  // Vector on data bits 7..0
   output logic            data_lo_oe    // Drive enable for data bits 7..0
);

   // ************************************************************
   // Priority search
   // ************************************************************
   // Returns {found, index} of the lowest set bit.
   function automatic logic [3:0] first_set(input logic [7:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 7; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction : first_set

   // ************************************************************
   // Registers
   // ************************************************************
   logic [7:0]      serial_irq_status_r;
   logic [7:0]      dma_irq_status_r;
   logic [3:0]      timer_irq_status_r;
   logic [7:0]      serial_irq_enable_r;
   logic [7:0]      dma_irq_enable_r;
   logic [3:0]      timer_irq_enable_r;
   ivau_byte_t      fixed_vector_reg_r;
   logic [1:0]      mod_vec_hi_r;
   logic            prio_dma_first_r;
   logic [1:0]      ack_type_field_r;
   logic            vector_select_r;
   logic [1:0]      evt_stat_r;
   logic [1:0]      evt_mask_r;
   logic            ack_meta_r;
   logic            ack_sync_r;
   logic            ack_prev_r;
   ivau_ack_state_e st_r;
   ivau_ack_state_e st_nxt;

   // ************************************************************
   // Decode
   // ************************************************************
   wire logic       wr_ser_en  = reg_wr && (reg_addr == `IVAU_A_SER_EN);
   wire logic       wr_dma_en  = reg_wr && (reg_addr == `IVAU_A_DMA_EN);
   wire logic       wr_tmr_en  = reg_wr && (reg_addr == `IVAU_A_TMR_EN);
   wire logic       wr_fix     = reg_wr && (reg_addr == `IVAU_A_FIX_VEC);
   wire logic       wr_mod     = reg_wr && (reg_addr == `IVAU_A_MOD_VEC);
   wire logic       wr_ctrl    = reg_wr && (reg_addr == `IVAU_A_CTRL);
   wire logic       wr_evt     = reg_wr && (reg_addr == `IVAU_A_EVT_STAT);
   wire logic       wr_emask   = reg_wr && (reg_addr == `IVAU_A_EVT_MASK);

   // ************************************************************
   // Pending sources and priority
   // ************************************************************
   wire logic [7:0] ser_pend   = serial_irq_status_r & serial_irq_enable_r;
   wire logic [7:0] dma_pend   = dma_irq_status_r & dma_irq_enable_r;
   wire logic [3:0] tmr_pend   = timer_irq_status_r & timer_irq_enable_r;
   wire logic [1:0] evt_pend   = evt_stat_r & evt_mask_r;
   wire logic       src_pend   = (|ser_pend) || (|dma_pend) || (|tmr_pend);
   wire logic       irq_nxt    = src_pend || (|evt_pend);
   wire logic [3:0] ser_hit    = first_set(ser_pend);
   wire logic [3:0] dma_hit    = first_set(dma_pend);
   wire logic [3:0] tmr_hit    = first_set({4'h0, tmr_pend});

   // Serial codes are {channel,0,4+2k}; DMA codes {channel pair,1,4+2k}.
   wire logic [5:0] ser_code   = {ser_hit[2], 1'b0, 4'(4'h4 + {1'b0, ser_hit[1:0], 1'b0})};
   wire logic [5:0] dma_code   = {dma_hit[2], 1'b1, 4'(4'h4 + {1'b0, dma_hit[1:0], 1'b0})};
   wire logic [5:0] tmr_code   = {tmr_hit[1], 3'h7, tmr_hit[0], 1'b0};

   // Serial before DMA unless the priority bit swaps them; timers last.
   wire logic [5:0] first_code = prio_dma_first_r ? dma_code : ser_code;
   wire logic       first_hit  = prio_dma_first_r ? dma_hit[3] : ser_hit[3];
   wire logic [5:0] second_code = prio_dma_first_r ? ser_code : dma_code;
   wire logic       second_hit = prio_dma_first_r ? ser_hit[3] : dma_hit[3];
   wire logic [5:0] src_code   = first_hit  ? first_code  :
                                 second_hit ? second_code :
                                 tmr_hit[3] ? tmr_code    : `IVAU_NO_CODE;
   wire ivau_byte_t mod_vector = {mod_vec_hi_r, src_code};
   wire ivau_byte_t vec_sel    = vector_select_r ? mod_vector
                                                 : fixed_vector_reg_r;

   // ************************************************************
   // Acknowledge sequencing
   // ************************************************************
   wire logic       ack_fall   = ack_prev_r && !ack_sync_r;
   wire logic       ack_single = (ack_type_field_r == `IVAU_ACK_SINGLE);
   wire logic       ack_double = (ack_type_field_r == `IVAU_ACK_DOUBLE);
   wire logic       ack_on     = ack_single || ack_double;
   wire logic       stray_ack  = ack_fall && ack_on && !cpu_irq && (st_r != IVAU_DRIVE);
   wire logic       start_drv  = (st_r != IVAU_DRIVE) && (st_nxt == IVAU_DRIVE);
   wire logic       oe_nxt     = (st_nxt == IVAU_DRIVE) && ack_on;

   always_comb
   begin
      st_nxt = st_r;
      unique case (st_r)
         IVAU_IDLE:
         begin
            if (ack_fall && cpu_irq && ack_single)
            begin
               st_nxt = IVAU_DRIVE;
            end
            else if (ack_fall && cpu_irq && ack_double)
            begin
               st_nxt = IVAU_WAIT_SECOND;
            end
         end
         IVAU_WAIT_SECOND:
         begin
            if (!ack_double || (ack_fall && !cpu_irq))
            begin
               st_nxt = IVAU_IDLE;
            end
            else if (ack_fall)
            begin
               st_nxt = IVAU_DRIVE;
            end
         end
         IVAU_DRIVE:
         begin
            if (ack_sync_r || !ack_on)
            begin
               st_nxt = IVAU_IDLE;
            end
         end
      endcase
   end

   // ************************************************************
   // Read data
   // ************************************************************
   wire ivau_byte_t rd_mux =
      (reg_addr == `IVAU_A_SER_STAT) ? serial_irq_status_r :
      (reg_addr == `IVAU_A_DMA_STAT) ? dma_irq_status_r :
      (reg_addr == `IVAU_A_TMR_STAT) ? {timer_irq_status_r, 4'h0} :
      (reg_addr == `IVAU_A_SER_EN)   ? serial_irq_enable_r :
      (reg_addr == `IVAU_A_DMA_EN)   ? dma_irq_enable_r :
      (reg_addr == `IVAU_A_TMR_EN)   ? {timer_irq_enable_r, 4'h0} :
      (reg_addr == `IVAU_A_FIX_VEC)  ? fixed_vector_reg_r :
      (reg_addr == `IVAU_A_MOD_VEC)  ? {mod_vec_hi_r, 6'h00} :
      (reg_addr == `IVAU_A_CTRL)     ? {prio_dma_first_r, ack_type_field_r, vector_select_r, 4'h0} :
      (reg_addr == `IVAU_A_EVT_STAT) ? {6'h00, evt_stat_r} :
      (reg_addr == `IVAU_A_EVT_MASK) ? {6'h00, evt_mask_r} : `IVAU_RST_BYTE;

   // Event bits: a new event in the clearing cycle wins over the clear.
   wire logic [1:0] evt_set    = {stray_ack, start_drv};
   wire logic [1:0] evt_nxt    = (evt_stat_r & ~(wr_evt ? reg_wdata[1:0] : 2'h0)) | evt_set;

   // ************************************************************
   // Status and enables
   // ************************************************************
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         serial_irq_status_r <= `IVAU_RST_BYTE;
         dma_irq_status_r    <= `IVAU_RST_BYTE;
         timer_irq_status_r  <= 4'h0;
         serial_irq_enable_r <= `IVAU_RST_BYTE;
         dma_irq_enable_r    <= `IVAU_RST_BYTE;
         timer_irq_enable_r  <= 4'h0;
      end
      else
      begin
         serial_irq_status_r <= serial_req;
         dma_irq_status_r    <= dma_req;
         timer_irq_status_r  <= timer_req;
         if (wr_ser_en)
         begin
            serial_irq_enable_r <= reg_wdata;
         end
         if (wr_dma_en)
         begin
            dma_irq_enable_r <= reg_wdata;
         end
         if (wr_tmr_en)
         begin
            timer_irq_enable_r <= reg_wdata[7:4];
         end
      end
   end

   // ************************************************************
   // Vector and control registers
   // ************************************************************
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         fixed_vector_reg_r <= `IVAU_RST_BYTE;
         mod_vec_hi_r       <= 2'h0;
         prio_dma_first_r   <= 1'b0;
         ack_type_field_r   <= `IVAU_ACK_NONE;
         vector_select_r    <= 1'b0;
         evt_mask_r         <= 2'h0;
         evt_stat_r         <= 2'h0;
         reg_rdata          <= `IVAU_RST_BYTE;
      end
      else
      begin
         if (wr_fix)
         begin
            fixed_vector_reg_r <= reg_wdata;
         end
         if (wr_mod)
         begin
            mod_vec_hi_r <= reg_wdata[7:6];
         end
         if (wr_ctrl)
         begin
            prio_dma_first_r <= reg_wdata[`IVAU_CTL_IPC];
            ack_type_field_r <= reg_wdata[`IVAU_CTL_ACK_HI:`IVAU_CTL_ACK_LO];
            vector_select_r  <= reg_wdata[`IVAU_CTL_VOS];
         end
         if (wr_emask)
         begin
            evt_mask_r <= reg_wdata[1:0];
         end
         evt_stat_r <= evt_nxt;
         reg_rdata  <= reg_rd ? rd_mux : `IVAU_RST_BYTE;
      end
   end

   // ************************************************************
   // Acknowledge pin and vector drive
   // ************************************************************
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         ack_meta_r  <= 1'b1;
         ack_sync_r  <= 1'b1;
         ack_prev_r  <= 1'b1;
         st_r        <= IVAU_IDLE;
         cpu_irq     <= 1'b0;
         data_lo_out <= `IVAU_RST_BYTE;
         data_lo_oe  <= 1'b0;
      end
      else
      begin
         ack_meta_r <= cpu_ack_n;
         ack_sync_r <= ack_meta_r;
         ack_prev_r <= ack_sync_r;
         st_r       <= st_nxt;
         cpu_irq    <= irq_nxt;
         data_lo_oe <= oe_nxt;
         if (start_drv)
         begin
            data_lo_out <= vec_sel;
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   tmr_read_low_a: assert property (
      @(posedge core_clk) disable iff (rst)
      reg_rd && (reg_addr == `IVAU_A_TMR_STAT || reg_addr == `IVAU_A_TMR_EN)
      |=> reg_rdata[3:0] == 4'h0)
      else $error("Timer register low nibble read nonzero.");

   reset_clears_a: assert property (
      @(posedge core_clk)
      rst |=> (serial_irq_enable_r == 8'h00) && (dma_irq_enable_r == 8'h00)
              && (timer_irq_enable_r == 4'h0) && (timer_irq_status_r == 4'h0))
      else $error("Enable or status not cleared by reset.");

   tmr_status_follow_a: assert property (
      @(posedge core_clk) disable iff (rst)
      ##1 timer_irq_status_r == $past(timer_req))
      else $error("Timer status does not follow requests.");

   masked_no_irq_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !src_pend && (evt_pend == 2'h0) |=> !cpu_irq)
      else $error("Request raised with no enabled source.");

   no_ack_quiet_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !ack_on |=> !data_lo_oe)
      else $error("Bus driven with acknowledge disabled.");

   single_drive_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (st_r == IVAU_IDLE) && ack_fall && cpu_irq && ack_single
      |=> data_lo_oe && (data_lo_out == $past(vec_sel)))
      else $error("Single acknowledge did not drive the vector.");

   double_first_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (st_r == IVAU_IDLE) && ack_fall && cpu_irq && ack_double
      |=> !data_lo_oe ##0 (st_r == IVAU_WAIT_SECOND))
      else $error("Double acknowledge drove on first pulse.");

   stray_ack_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (st_r != IVAU_DRIVE) && ack_fall && !cpu_irq |=> !data_lo_oe)
      else $error("Vector driven with no request.");

   fixed_vector_a: assert property (
      @(posedge core_clk) disable iff (rst)
      start_drv && !vector_select_r |=> data_lo_out == $past(fixed_vector_reg_r))
      else $error("Fixed vector not output unmodified.");

   mod_vector_a: assert property (
      @(posedge core_clk) disable iff (rst)
      start_drv && vector_select_r
      |=> (data_lo_out[7:6] == $past(mod_vec_hi_r)) && (data_lo_out[5:0] == $past(src_code)))
      else $error("Modified vector fields wrong.");

   prio_code_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !prio_dma_first_r && ser_pend[0] |-> src_code == 6'h04)
      else $error("Highest priority code not selected.");

   double_second_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (st_r == IVAU_WAIT_SECOND) && ack_fall && cpu_irq && ack_double
      |=> data_lo_oe && (data_lo_out == $past(vec_sel)))
      else $error("Double acknowledge did not drive on second pulse.");

   irq_raise_a: assert property (
      @(posedge core_clk) disable iff (rst)
      src_pend |=> cpu_irq)
      else $error("Enabled pending source did not raise the request.");

   drive_release_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (st_r == IVAU_DRIVE) && ack_sync_r |=> !data_lo_oe)
      else $error("Vector still driven after acknowledge ended.");

endmodule : ivau_top

// [dv/ivau_host_model.sv]
// Host processor model that answers interrupts with acknowledge pulses.
// Assumes one clock shared with the interrupt vector unit.
module ivau_host_model
   import ivau_pkg::*;
(
   input  wire logic       core_clk,     // Shared clock
   input  wire ivau_byte_t data_lo_out,  // Vector on data bits 7..0
   input  wire logic       data_lo_oe,   // Device drives data bits 7..0
   output logic            cpu_ack_n     // Acknowledge pin, active low
);
   timeunit 1ns;
   timeprecision 1ns;

   initial cpu_ack_n = 1'b1;

   // ************************************************************
   // Acknowledge pulses
   // ************************************************************
   // One low pulse of eight cycles, then eight idle cycles for the
   // synchroniser to see the pin high again.
   task automatic pulse(output logic seen, output ivau_byte_t v);
      seen = 1'b0;
      v    = 8'h00;
      @(posedge core_clk);
      cpu_ack_n <= 1'b0;
      repeat (8)
      begin
         @(negedge core_clk);
         if (data_lo_oe === 1'b1 && !seen)
         begin
            seen = 1'b1;
            v    = data_lo_out;
         end
      end
      @(posedge core_clk);
      cpu_ack_n <= 1'b1;
      repeat (8) @(posedge core_clk);
   endtask : pulse

   // In double mode the vector is taken only from the second pulse.
   task automatic seq(input logic dbl, output logic first_oe, output logic last_oe,
                      output ivau_byte_t v);
      first_oe = 1'b0;
      if (dbl)
      begin
         pulse(first_oe, v);
      end
      pulse(last_oe, v);
   endtask : seq
endmodule : ivau_host_model

// [dv/tb.sv]
// Self-checking bench for the interrupt vector unit.
// Assumes the host model file is compiled first.
`include "ivau_regs.svh"

module tb
   import ivau_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [5:0] CODES [20] = '{6'h04, 6'h06, 6'h08, 6'h0A, 6'h24, 6'h26, 6'h28, 6'h2A,
      6'h14, 6'h16, 6'h18, 6'h1A, 6'h34, 6'h36, 6'h38, 6'h3A, 6'h1C, 6'h1E, 6'h3C, 6'h3E};

   logic       core_clk;
   logic       rst;
   logic [3:0] reg_addr;
   ivau_byte_t reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   ivau_byte_t reg_rdata;
   ivau_byte_t serial_req;
   ivau_byte_t dma_req;
   logic [3:0] timer_req;
   logic       cpu_ack_n;
   logic       cpu_irq;
   ivau_byte_t data_lo_out;
   logic       data_lo_oe;
   int         n_fail;
   int         compares;
   ivau_byte_t d;
   ivau_byte_t v;
   logic       o1;
   logic       o2;
   logic       ia;

   ivau_top u_ivau_top (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_req(serial_req),
      .dma_req(dma_req), .timer_req(timer_req), .cpu_ack_n(cpu_ack_n), .cpu_irq(cpu_irq),
      .data_lo_out(data_lo_out), .data_lo_oe(data_lo_oe));

   ivau_host_model u_ivau_host_model (.core_clk(core_clk), .data_lo_out(data_lo_out),
      .data_lo_oe(data_lo_oe), .cpu_ack_n(cpu_ack_n));

   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // ************************************************************
   // Access and check tasks
   // ************************************************************
   task automatic chk(input string nm, input ivau_byte_t seen, input ivau_byte_t exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input ivau_byte_t wd);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= wd;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output ivau_byte_t rv);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      @(negedge core_clk);
      rv = reg_rdata;
   endtask : rd

   task automatic req(input ivau_byte_t s, input ivau_byte_t dm, input logic [3:0] t);
      @(posedge core_clk);
      serial_req <= s;
      dma_req    <= dm;
      timer_req  <= t;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
   endtask : req

   task automatic results;
      $display("checks %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   initial
   begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      results();
   end

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial
   begin
      n_fail = 0;
      compares = 0;
      rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      serial_req = 8'h00;
      dma_req = 8'h00;
      timer_req = 4'h0;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < 12; i++)
      begin
         rd(i[3:0], d);
         chk("reset value", d, 8'h00);
      end
      for (int i = 0; i < 4; i++)
      begin
         req(8'h00, 8'h00, 4'h1 << i);
         wr(`IVAU_A_TMR_STAT, 8'hFF);
         rd(`IVAU_A_TMR_STAT, d);
         chk("timer status", d, {4'h1 << i, 4'h0});
      end
      req(8'h01, 8'h01, 4'h1);
      chk("irq disabled", {7'h00, cpu_irq}, 8'h00);
      wr(`IVAU_A_TMR_EN, 8'hF0);
      rd(`IVAU_A_TMR_EN, d);
      chk("timer enable", d, 8'hF0);
      req(8'h01, 8'h01, 4'h1);
      chk("irq timer", {7'h00, cpu_irq}, 8'h01);
      wr(`IVAU_A_TMR_EN, 8'h00);
      wr(`IVAU_A_DMA_EN, 8'hFF);
      req(8'h01, 8'h01, 4'h0);
      chk("irq dma", {7'h00, cpu_irq}, 8'h01);
      wr(`IVAU_A_DMA_EN, 8'h00);
      wr(`IVAU_A_SER_EN, 8'hFE);
      req(8'h01, 8'h00, 4'h0);
      chk("irq masked source", {7'h00, cpu_irq}, 8'h00);
      wr(`IVAU_A_SER_EN, 8'hFF);
      wr(`IVAU_A_DMA_EN, 8'hFF);
      wr(`IVAU_A_TMR_EN, 8'hF0);
      wr(`IVAU_A_FIX_VEC, 8'hA5);
      wr(`IVAU_A_MOD_VEC, 8'hC0);
      rd(`IVAU_A_MOD_VEC, d);
      chk("modified vector", d, 8'hC0);
      req(8'h01, 8'h00, 4'h0);
      // Control byte: ack type in bits 6..5, vector select in bit 4.
      foreach (CODES[i])
      begin
         case (i)
            0: d = 8'h00;
            1: d = 8'h60;
            2: d = 8'h20;
            3: d = 8'h40;
            default: d = 8'h50;
         endcase
         if (i > 4)
            break;
         wr(`IVAU_A_CTRL, d);
         u_ivau_host_model.seq(d[6:5] == 2'h2, o1, o2, v);
         chk("first pulse drive", {7'h00, o1}, 8'h00);
         chk("vector drive", {7'h00, o2}, {7'h00, i > 1});
         chk("vector", v, (i < 2) ? 8'h00 : (i < 4) ? 8'hA5 : 8'hC4);
      end
      wr(`IVAU_A_CTRL, 8'h30);
      foreach (CODES[i])
      begin
         req((i < 8) ? 8'h01 << i : 8'h00, (i >= 8 && i < 16) ? 8'h01 << (i - 8) : 8'h00,
             (i >= 16) ? 4'h1 << (i - 16) : 4'h0);
         u_ivau_host_model.seq(1'b0, o1, o2, v);
         chk("source vector", v, {2'h3, CODES[i]});
      end
      req(8'h80, 8'h01, 4'h8);
      u_ivau_host_model.seq(1'b0, o1, o2, v);
      chk("serial first", v, 8'hEA);
      wr(`IVAU_A_CTRL, 8'hB0);
      u_ivau_host_model.seq(1'b0, o1, o2, v);
      chk("dma first", v, 8'hD4);
      rd(`IVAU_A_EVT_STAT, d);
      chk("event vector", d, 8'h01);
      wr(`IVAU_A_EVT_STAT, 8'h03);
      rd(`IVAU_A_EVT_STAT, d);
      chk("event cleared", d, 8'h00);
      req(8'h00, 8'h00, 4'h0);
      chk("irq idle", {7'h00, cpu_irq}, 8'h00);
      u_ivau_host_model.seq(1'b0, o1, o2, v);
      chk("stray drive", {7'h00, o2}, 8'h00);
      rd(`IVAU_A_EVT_STAT, d);
      chk("event stray", d, 8'h02);
      wr(`IVAU_A_EVT_MASK, 8'h00);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      ia = cpu_irq;
      chk("event masked", {7'h00, ia}, 8'h00);
      wr(`IVAU_A_EVT_MASK, 8'h03);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk("event mask effect", {7'h00, ia ^ cpu_irq}, 8'h01);
      wr(`IVAU_A_EVT_STAT, 8'h03);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk("irq after clear", {7'h00, cpu_irq}, 8'h00);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rd(`IVAU_A_SER_EN, d);
      chk("second reset", d, 8'h00);
      rd(`IVAU_A_CTRL, d);
      chk("second reset ctrl", d, 8'h00);
      results();
   end
endmodule : tb
